/* File: rtl/pomc_params.svh */
// Constants for the operating-mode controller
`ifndef POMC_PARAMS_SVH
`define POMC_PARAMS_SVH
`define POMC_CLK_HZ          50000000
`define POMC_BLINK_MIN_S     3
`define POMC_BLINK_MIN_CYC   (`POMC_CLK_HZ * `POMC_BLINK_MIN_S)
`define POMC_BLINK_HALF_CYC  12500000
`define POMC_BP_COUNT        3
`define POMC_STEP_BP_MAX     2
`define POMC_ADDR_CTRL       4'h0
`define POMC_ADDR_BP_EN      4'h1
`define POMC_ADDR_STATUS     4'h2
`define POMC_ADDR_CYCLES     4'h3
`define POMC_CTRL_START_BIT  0
`define POMC_CTRL_STOP_BIT   1
`define POMC_CTRL_STEP_BIT   2
`define POMC_CTRL_RESUME_BIT 3
`define POMC_CTRL_CLRBP_BIT  4
`endif

/* File: rtl/pomc_pkg.sv */
// Types shared by the operating-mode controller
`default_nettype none
package pomc_pkg;
    typedef enum logic [1:0] {
        POMC_STOP,
        POMC_STARTUP,
        POMC_RUN,
        POMC_HOLD
    } pomc_mode_type;

    typedef struct packed {
        logic run_lamp;
        logic stop_lamp;
        logic output_inhibit;
    } pomc_lamps_type;
endpackage
`default_nettype wire

/* File: rtl/pomc_ctrl.sv */
// Operating-mode controller: stop, start-up, run, hold with breakpoints
`include "pomc_params.svh"
`default_nettype none
module pomc_ctrl
    import pomc_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    // Register port
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    // Program engine handshake (same clock, except comm_link_up_i, which is synchronised below)
    input  wire logic        startup_done_i,
    input  wire logic        cycle_end_i,
    input  wire logic [1:0]  bp_hit_idx_i,
    input  wire logic        bp_hit_i,
    input  wire logic        alarm_req_i,
    input  wire logic        fault_stop_i,
    input  wire logic        comm_link_up_i,
    output logic             startup_program_block_o,
    output logic             cyclic_main_block_o,
    output logic             alarm_section_en_o,
    output logic             exec_en_o,
    output logic             timer_en_o,
    output logic             image_refresh_o,
    output logic             step_grant_o,
    output logic             regs_visible_o,
    output logic             comm_processor_link_o,
    // Indicators
    output logic             output_inhibit_o,
    output logic             run_lamp_o,
    output logic             stop_lamp_o,
    output logic [1:0]       mode_o
);

    // ----------------------------------------------------------------
    // Registers and wires
    // ----------------------------------------------------------------
    // State, counters and decoded helpers
    pomc_mode_type             mode_q;
    pomc_mode_type             mode_d;
    logic [`POMC_BP_COUNT-1:0] bp_en_q;
    logic [1:0]                bp_active_cnt;
    logic                      step_pending_q;
    logic                      step_refused_q;
    logic [31:0]               blink_min_q;
    logic [23:0]               blink_div_q;
    logic                      blink_phase_q;
    logic [31:0]               cycle_cnt_q;
    logic                      bp_hit_ok;
    pomc_lamps_type            lamps_d;
    logic                      link_meta_q;
    logic                      link_sync_q;

    // Command strobes decoded from a write to the control word
    wire logic wr_ctrl = reg_wr_i && (reg_addr_i == `POMC_ADDR_CTRL);
    wire logic cmd_start  = wr_ctrl && reg_wdata_i[`POMC_CTRL_START_BIT];
    wire logic cmd_stop   = wr_ctrl && reg_wdata_i[`POMC_CTRL_STOP_BIT];
    wire logic cmd_step   = wr_ctrl && reg_wdata_i[`POMC_CTRL_STEP_BIT];
    wire logic cmd_resume = wr_ctrl && reg_wdata_i[`POMC_CTRL_RESUME_BIT];
    wire logic cmd_clrbp  = wr_ctrl && reg_wdata_i[`POMC_CTRL_CLRBP_BIT];

    // ----------------------------------------------------------------
    // Breakpoints
    // ----------------------------------------------------------------
    // Enables live in one word; the tool may change them in any mode,
    // hold included, and a clear command drops all three at once
    // Count of enabled breakpoints, up to three
    always_comb
    begin
        bp_active_cnt = 2'h0;
        for (int i = 0; i < `POMC_BP_COUNT; i++)
        begin
            bp_active_cnt = bp_active_cnt + {1'b0, bp_en_q[i]};
        end
    end

    // A hit only counts when its breakpoint is enabled
    // An index beyond the third entry reads as no hit
    assign bp_hit_ok = bp_hit_i && (bp_hit_idx_i < 2'(`POMC_BP_COUNT))
                       && bp_en_q[bp_hit_idx_i];

    // Breakpoint enables are writable in any mode, no test mode needed
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            bp_en_q <= '0;
        else if (cmd_clrbp)
            bp_en_q <= '0;
        else if (reg_wr_i && (reg_addr_i == `POMC_ADDR_BP_EN))
            bp_en_q <= reg_wdata_i[`POMC_BP_COUNT-1:0];
    end

    // ----------------------------------------------------------------
    // Mode machine
    // ----------------------------------------------------------------
    // Stop and fault are tested last so that they override any advance
    // chosen above in the same cycle. Hold is left by stop, by resume or
    // by an accepted step; a step with three breakpoints enabled is
    // dropped and only flagged in status.
    // Next mode; stop command and faults take priority over all
    always_comb
    begin
        mode_d = mode_q;
        unique case (mode_q)
            POMC_STOP:
            begin
                if (cmd_start)
                    mode_d = POMC_STARTUP;
            end
            POMC_STARTUP:
            begin
                if (startup_done_i)
                    mode_d = POMC_RUN;
            end
            POMC_RUN:
            begin
                // A stepped statement ends with its pass, then hold again
                if (bp_hit_ok || (step_pending_q && cycle_end_i))
                    mode_d = POMC_HOLD;
            end
            POMC_HOLD:
            begin
                if (cmd_resume || (cmd_step && (bp_active_cnt <= 2'(`POMC_STEP_BP_MAX))))
                    mode_d = POMC_RUN;
            end
        endcase
        if (cmd_stop || fault_stop_i)
            mode_d = POMC_STOP;
    end

    // Mode register; reset lands in stop
    // Registered outputs come out of reset showing stop as well
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            mode_q <= POMC_STOP;
        else
            mode_q <= mode_d;
    end

    // Single step: run one statement, then return to hold
    // Resume wins when both bits are written in one word
    // Cleared once out of run, so a stale step never replays
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            step_pending_q <= 1'b0;
        else if (mode_q == POMC_HOLD && mode_d == POMC_RUN)
            step_pending_q <= cmd_step && !cmd_resume;
        else if (mode_q != POMC_RUN)
            step_pending_q <= 1'b0;
    end

    // Sticky refusal flag, cleared by the next accepted step
    // Set and clear never meet: one step strobe does one or the other
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            step_refused_q <= 1'b0;
        else if (mode_q == POMC_HOLD && cmd_step
                 && bp_active_cnt > 2'(`POMC_STEP_BP_MAX))
            step_refused_q <= 1'b1;
        else if (mode_q == POMC_HOLD && cmd_step)
            step_refused_q <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Lamp timing
    // ----------------------------------------------------------------
    // Lamp patterns: stop lit in stop and hold, run steady in run,
    // blinking in start-up and hold. All blinking shares one phase,
    // so no lamp can drift against another.
    // Limitation: a new start inside a running window re-arms it in full
    // Minimum blink window, armed once the start-up block begins
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            blink_min_q <= '0;
        else if (mode_q == POMC_STOP && mode_d == POMC_STARTUP)
            blink_min_q <= 32'(`POMC_BLINK_MIN_CYC);
        else if (blink_min_q != '0)
            blink_min_q <= blink_min_q - 32'h1;
    end

    // Free-running blink divider; the trade is a shared phase for all
    // Half period is a quarter second at the system clock
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            blink_div_q   <= '0;
            blink_phase_q <= 1'b0;
        end
        else if (blink_div_q == 24'(`POMC_BLINK_HALF_CYC - 1))
        begin
            blink_div_q   <= '0;
            blink_phase_q <= !blink_phase_q;
        end
        else
            blink_div_q <= blink_div_q + 24'h1;
    end

    // Lamps and inhibit from the next mode so outputs track the mode
    always_comb
    begin
        lamps_d.output_inhibit = (mode_d != POMC_RUN);
        lamps_d.stop_lamp      = (mode_d == POMC_STOP) || (mode_d == POMC_HOLD);
        unique case (mode_d)
            POMC_STOP:
            begin
                lamps_d.run_lamp = 1'b0;
            end
            POMC_STARTUP:
            begin
                lamps_d.run_lamp = blink_phase_q;
            end
            POMC_RUN:
            begin
                lamps_d.run_lamp = 1'b1;
            end
            POMC_HOLD:
            begin
                lamps_d.run_lamp = blink_phase_q;
            end
        endcase
        // Blink window outlasts a short start-up or an early stop
        if (blink_min_q > 32'h1)
        begin
            lamps_d.run_lamp  = blink_phase_q;
            lamps_d.stop_lamp = (mode_d == POMC_STOP) || (mode_d == POMC_HOLD);
        end
    end

    // Indicator outputs registered
    // Reset values show stop: inhibit on, stop lamp lit
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            output_inhibit_o <= 1'b1;
            run_lamp_o       <= 1'b0;
            stop_lamp_o      <= 1'b1;
            mode_o           <= 2'h0;
        end
        else
        begin
            output_inhibit_o <= lamps_d.output_inhibit;
            run_lamp_o       <= lamps_d.run_lamp;
            stop_lamp_o      <= lamps_d.stop_lamp;
            mode_o           <= mode_d;
        end
    end

    // ----------------------------------------------------------------
    // Execution control
    // ----------------------------------------------------------------
    // Every enable except image_refresh_o is registered from the next mode, so the engine sees
    // the new mode on the same edge as the mode output changes.
    // Timers run only in run, which freezes them in hold and stop.
    // Enables for the program engine; stop and hold freeze everything,
    // so retained data is left as it was
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            startup_program_block_o <= 1'b0;
            cyclic_main_block_o     <= 1'b0;
            alarm_section_en_o      <= 1'b0;
            exec_en_o               <= 1'b0;
            timer_en_o              <= 1'b0;
            image_refresh_o         <= 1'b0;
            step_grant_o            <= 1'b0;
            regs_visible_o          <= 1'b0;
        end
        else
        begin
            startup_program_block_o <= (mode_d == POMC_STARTUP);
            cyclic_main_block_o     <= (mode_d == POMC_RUN);
            alarm_section_en_o      <= (mode_d == POMC_RUN) && alarm_req_i;
            exec_en_o               <= (mode_d == POMC_RUN)
                                       || (mode_d == POMC_STARTUP);
            timer_en_o              <= (mode_d == POMC_RUN);
            image_refresh_o         <= (mode_q == POMC_RUN) && cycle_end_i;
            step_grant_o            <= (mode_q == POMC_HOLD) && (mode_d == POMC_RUN)
                                       && cmd_step && !cmd_resume;
            regs_visible_o          <= (mode_d == POMC_HOLD);
        end
    end

    // Comm links are never dropped because of hold
    // Status comes from the link's own clock, so two flops first
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            link_meta_q           <= 1'b0;
            link_sync_q           <= 1'b0;
            comm_processor_link_o <= 1'b0;
        end
        else
        begin
            link_meta_q           <= comm_link_up_i;
            link_sync_q           <= link_meta_q;
            comm_processor_link_o <= link_sync_q;
        end
    end

    // Main-block pass counter; a stepped pass drops back to hold
    // Wraps silently; software works with differences
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            cycle_cnt_q <= '0;
        else if (mode_q == POMC_RUN && cycle_end_i)
            cycle_cnt_q <= cycle_cnt_q + 32'h1;
    end

    // ----------------------------------------------------------------
    // Register read
    // ----------------------------------------------------------------
    // Word map, four-bit word address:
    //   0 control, write only: bit0 start, bit1 stop, bit2 step,
    //     bit3 resume, bit4 clear all breakpoints
    //   1 breakpoint enables, bits 2:0, read and write
    //   2 status, read only: bit7 step pending, bit6 step refused,
    //     bits 5:4 enabled breakpoint count, bits 1:0 mode
    //   3 completed main-block passes, read only
    //   Control and any other word read as zero
    // Read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            reg_rdata_o <= '0;
        else if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                `POMC_ADDR_BP_EN:  reg_rdata_o <= {29'h0, bp_en_q};
                `POMC_ADDR_STATUS: reg_rdata_o <= {24'h0, step_pending_q,
                                                   step_refused_q, bp_active_cnt,
                                                   2'h0, mode_q};
                `POMC_ADDR_CYCLES: reg_rdata_o <= cycle_cnt_q;
                default:           reg_rdata_o <= '0;
            endcase
        end
        else
            reg_rdata_o <= '0;
    end

endmodule
`default_nettype wire

/* File: bench/pomc_ctrl_properties.sv */
// Port-level checker of the mode controller
`default_nettype none
module pomc_ctrl_properties
(
    // Clock, reset and causes
    input wire logic        ref_clk_i,
    input wire logic        rst_b_i,
    input wire logic [3:0]  reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        startup_done_i,
    input wire logic        cycle_end_i,
    input wire logic        bp_hit_i,
    input wire logic        fault_stop_i,
    input wire logic        comm_link_up_i,
    input wire logic        alarm_req_i,
    // Watched outputs
    input wire logic        alarm_section_en_o,
    input wire logic        startup_program_block_o,
    input wire logic        exec_en_o,
    input wire logic        timer_en_o,
    input wire logic        image_refresh_o,
    input wire logic        step_grant_o,
    input wire logic        regs_visible_o,
    input wire logic        comm_processor_link_o,
    input wire logic        output_inhibit_o,
    input wire logic        stop_lamp_o,
    input wire logic [1:0]  mode_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    // Stop requests outrank every advance
    logic stop_req;
    assign stop_req = fault_stop_i || (reg_wr_i && reg_addr_i == 4'h0 && reg_wdata_i[1]);

    a_reset_stop: assert property (disable iff (1'b0) !rst_b_i |=> mode_o == 2'h0)
        else $error("mode not stop after reset");
    a_inhibit_mode: assert property (output_inhibit_o == (mode_o != 2'h2))
        else $error("inhibit wrong for mode");
    a_start_enter: assert property (mode_o == 2'h0 && reg_wr_i && reg_addr_i == 4'h0
        && reg_wdata_i[0] && !stop_req |=> mode_o == 2'h1 && startup_program_block_o)
        else $error("start did not enter start-up");
    a_startup_run: assert property (mode_o == 2'h1 && startup_done_i && !stop_req
        |=> mode_o == 2'h2)
        else $error("start-up end did not reach run");
    a_fault_stop: assert property (fault_stop_i |=> mode_o == 2'h0 && stop_lamp_o)
        else $error("fault did not stop");
    a_stop_lamp: assert property (stop_lamp_o == (mode_o == 2'h0 || mode_o == 2'h3))
        else $error("stop lamp wrong for mode");
    a_hold_halts: assert property (mode_o == 2'h3 |-> !exec_en_o && !timer_en_o
        && regs_visible_o)
        else $error("hold still executing");
    a_refresh_cycle: assert property (mode_o == 2'h2 && cycle_end_i && !bp_hit_i && !stop_req
        |=> image_refresh_o)
        else $error("image not refreshed");
    a_grant_hold: assert property (step_grant_o |-> mode_o == 2'h2 && $past(mode_o) == 2'h3)
        else $error("step granted outside hold");
    a_link_kept: assert property ($past(rst_b_i, 3) |->
        comm_processor_link_o == $past(comm_link_up_i, 3))
        else $error("link status not kept");
    a_alarm_run: assert property (alarm_section_en_o
        == ($past(alarm_req_i) && mode_o == 2'h2))
        else $error("alarm section outside run");
endmodule
bind pomc_ctrl pomc_ctrl_properties pomc_ctrl_properties_i (.*);
`default_nettype wire

/* File: bench/pomc_engine_model.sv */
// Program engine and tool model behind the controller
`default_nettype none
module pomc_engine_model
(
    // Clock and bench commands
    input  wire logic       ref_clk_i,
    input  wire logic       rst_b_i,
    input  wire logic [3:0] done_dly_i,
    input  wire logic       hit_req_i,
    input  wire logic [1:0] hit_idx_i,
    // Controller side
    input  wire logic       startup_program_block_i,
    input  wire logic       cyclic_main_block_i,
    output logic            startup_done_o,
    output logic            cycle_end_o,
    output logic            bp_hit_o,
    output logic [1:0]      bp_hit_idx_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] su_cnt_q;
    logic [1:0] pass_cnt_q;
    // Start-up block length is set by the bench, no limit applies
    always_ff @(posedge ref_clk_i)
    begin
        su_cnt_q       <= startup_program_block_i ? su_cnt_q + 4'h1 : 4'h0;
        startup_done_o <= startup_program_block_i && su_cnt_q == done_dly_i;
    end
    // One main-block pass every four cycles while running
    always_ff @(posedge ref_clk_i)
    begin
        pass_cnt_q  <= cyclic_main_block_i ? pass_cnt_q + 2'h1 : 2'h0;
        cycle_end_o <= cyclic_main_block_i && pass_cnt_q == 2'h3;
    end
    // Index wanders when unused so a stale value is never trusted
    always_ff @(posedge ref_clk_i)
    begin
        bp_hit_o     <= hit_req_i;
        bp_hit_idx_o <= !rst_b_i ? 2'h0 : hit_req_i ? hit_idx_i : bp_hit_idx_o + 2'h1;
    end
endmodule
`default_nettype wire

/* File: bench/plc_operating_mode_control_test.sv */
// Self-checking bench of the mode controller
`default_nettype none
module plc_operating_mode_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    // Expected port snapshots: mode, inhibit, stop lamp, regs, exec, timer, main, start-up
    localparam logic [8:0] ST_STOP = 9'h060, ST_SU = 9'h0c9, ST_RUN = 9'h10e, ST_HOLD = 9'h1f0;
    logic        clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, fault = 1'b0;
    logic        alarm = 1'b0, link = 1'b0, hit_req = 1'b0, snap_q = 1'b0, rd_d = 1'b0;
    logic [3:0]  addr = 4'h0, dly = 4'hf, n_grant = 4'h0;
    logic [31:0] wdata = 32'h0, rnd = 32'hc7bd, rdata;
    logic [1:0]  hit_idx = 2'h0, mode, bp_idx;
    logic        su_done, cyc_end, bp_hit, grant, su_blk, cyc_blk, inhibit, stop_lamp, rv, exec;
    logic        timer;
    logic [12:0] notes[$];
    logic [12:0] exp_v, seen;
    int          n_mismatch = 0, check_count = 0;

    pomc_ctrl pomc_ctrl_i (.ref_clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .startup_done_i(su_done), .cycle_end_i(cyc_end), .bp_hit_idx_i(bp_idx),
        .bp_hit_i(bp_hit), .alarm_req_i(alarm), .fault_stop_i(fault), .comm_link_up_i(link),
        .startup_program_block_o(su_blk), .cyclic_main_block_o(cyc_blk),
        .alarm_section_en_o(), .exec_en_o(exec), .timer_en_o(timer), .image_refresh_o(),
        .step_grant_o(grant), .regs_visible_o(rv), .comm_processor_link_o(),
        .output_inhibit_o(inhibit), .run_lamp_o(), .stop_lamp_o(stop_lamp), .mode_o(mode));
    pomc_engine_model pomc_engine_model_i (.ref_clk_i(clk), .rst_b_i(rst_b),
        .done_dly_i(dly), .hit_req_i(hit_req), .hit_idx_i(hit_idx),
        .startup_program_block_i(su_blk), .cyclic_main_block_i(cyc_blk),
        .startup_done_o(su_done), .cycle_end_o(cyc_end), .bp_hit_o(bp_hit),
        .bp_hit_idx_o(bp_idx));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
    endfunction
    // Clock, and random alarm and link levels
    always #10 clk = ~clk;
    always @(posedge clk)
    begin
        rnd <= lfsr(rnd);
        alarm <= rnd[0];
        link <= rnd[3];
    end
    // Oldest note against whichever result shows at this edge
    always @(posedge clk)
    begin
        if (grant === 1'b1)
            n_grant = n_grant + 4'h1;
        if (rd_d || snap_q)
        begin
            exp_v = notes.pop_front();
            seen = rd_d ? {5'h0, rdata[7:0]}
                        : {n_grant, mode, inhibit, stop_lamp, rv, exec, timer, cyc_blk, su_blk};
            check_count++;
            if (seen !== exp_v)
            begin
                n_mismatch++;
                $display("[FAIL] %s expected %h seen %h", rd_d ? "status" : "ports", exp_v, seen);
            end
        end
        rd_d <= rd;
    end
    // ----------------------------------------------------------------
    // Bus and engine tasks
    // ----------------------------------------------------------------
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_mode(input logic [7:0] s);
        @(posedge clk);
        addr <= 4'h2;
        rd <= 1'b1;
        notes.push_back({5'h0, s});
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task automatic snap(input logic [3:0] g, input logic [8:0] v);
        @(posedge clk);
        snap_q <= 1'b1;
        notes.push_back({g, v});
        @(posedge clk);
        snap_q <= 1'b0;
    endtask
    task automatic hit(input logic [1:0] i);
        @(posedge clk);
        hit_req <= 1'b1;
        hit_idx <= i;
        @(posedge clk);
        hit_req <= 1'b0;
        @(posedge clk);
    endtask
    // Bounded wait, so a stuck mode cannot hang the run
    task automatic wait_mode(input logic [1:0] m);
        for (int k = 0; k < 64; k++)
        begin
            @(posedge clk);
            if (mode === m)
                break;
        end
        check_count++;
        if (mode !== m)
        begin
            n_mismatch++;
            $display("[FAIL] mode expected %h seen %h", m, mode);
        end
    endtask
    task automatic end_sim;
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Main sequence: stop, aborted start-up, run, hold and stepping
    initial
    begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        snap(4'h0, ST_STOP);
        rd_mode(8'h00);
        wr_reg(4'h0, 32'h1);
        snap(4'h0, ST_SU);
        @(posedge clk) fault <= 1'b1;
        @(posedge clk) fault <= 1'b0;
        snap(4'h0, ST_STOP);
        dly <= 4'h1;
        wr_reg(4'h0, 32'h1);
        wait_mode(2'h2);
        snap(4'h0, ST_RUN);
        wr_reg(4'h1, 32'h1);
        hit(2'h2);
        snap(4'h0, ST_RUN);
        hit(2'h0);
        snap(4'h0, ST_HOLD);
        rd_mode(8'h13);
        wr_reg(4'h0, 32'h4);
        wait_mode(2'h3);
        snap(4'h1, ST_HOLD);
        wr_reg(4'h1, 32'h7);
        wr_reg(4'h0, 32'h4);
        snap(4'h1, ST_HOLD);
        rd_mode(8'h73);
        wr_reg(4'h1, 32'h3);
        wr_reg(4'h0, 32'h4);
        wait_mode(2'h3);
        snap(4'h2, ST_HOLD);
        wr_reg(4'h0, 32'h8);
        wait_mode(2'h2);
        wr_reg(4'h0, 32'h10);
        hit(2'h0);
        snap(4'h2, ST_RUN);
        wr_reg(4'h0, 32'h2);
        snap(4'h2, ST_STOP);
        rd_mode(8'h00);
        end_sim();
    end
    // Watchdog well past the expected hundred or so cycles
    initial
    begin
        #(20 * 4000);
        n_mismatch++;
        end_sim();
    end
endmodule
`default_nettype wire
